// >>> design/stg_pkg.sv
// Purpose: shared constants and types for the system timeout guard
// Assumes: one 10 MHz clock, host I/O cycles arrive already on that clock
// Notes:   offsets are the configuration-space indices seen through the data port
package stg_pkg;

  // host I/O port addresses
  localparam logic [15:0] INDEX_PORT   = 16'h002e;
  localparam logic [15:0] DATA_PORT    = 16'h002f;

  // key values written to the index port
  localparam logic [7:0]  UNLOCK_KEY   = 8'h87;
  localparam logic [7:0]  LOCK_KEY     = 8'haa;

  // configuration register indices
  localparam logic [7:0]  REG_LDN      = 8'h07;
  localparam logic [7:0]  REG_PINFN    = 8'h2b;
  localparam logic [7:0]  REG_ACT      = 8'h30;
  localparam logic [7:0]  REG_UNIT     = 8'hf5;
  localparam logic [7:0]  REG_COUNT    = 8'hf6;
  localparam logic [7:0]  REG_ARLD     = 8'hf7;

  // logical device number that owns the guard
  localparam logic [7:0]  LDN_GUARD    = 8'h08;

  // field positions
  localparam int          UNIT_MIN_BIT = 3;
  localparam int          PIN_GP_BIT   = 4;
  localparam int          ACT_EN_BIT   = 0;
  localparam int          ARLD_HI_BIT  = 7;
  localparam int          ARLD_LO_BIT  = 6;

  // reset values
  localparam logic [7:0]  RST_LDN      = 8'h00;
  localparam logic [7:0]  RST_PINFN    = 8'h00;
  localparam logic [7:0]  RST_ACT      = 8'h00;
  localparam logic [7:0]  RST_UNIT     = 8'h00;
  localparam logic [7:0]  RST_COUNT    = 8'h00;
  localparam logic [7:0]  RST_ARLD     = 8'h00;
  localparam logic [7:0]  RST_INDEX    = 8'h00;

  // answer to reads that reach nothing
  localparam logic [7:0]  IDLE_RDATA   = 8'hff;

  // timing
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          UNIT_SEC_S   = 1;
  localparam int          SEC_CYCLES   = UNIT_SEC_S * CLK_HZ;
  localparam int          MIN_SECONDS  = 60;

  typedef enum logic [2:0] {
    ST_LOCKED = 3'b001,
    ST_HALF   = 3'b010,
    ST_OPEN   = 3'b100
  } stg_port_state_t;

endpackage

// >>> design/stg_top.sv
// Purpose: system timeout guard behind an index/data configuration port
// Assumes: io strobes are one-cycle pulses on mclk; activity inputs are async pins
// Notes:   timeout_output is held until the count is rewritten or reset
`timescale 1ns/1ps
`default_nettype none
module stg_top #(
  parameter int SEC_CYCLES = stg_pkg::SEC_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  input  wire logic        kbd_activity,
  input  wire logic        mouse_activity,
  output logic             timeout_output,
  output logic             pin_out,
  output logic             pin_oe
);
  import stg_pkg::*;

  // refused at elaboration: a prescaler under two cycles cannot give a one-cycle tick
  if (SEC_CYCLES < 2) begin : g_bad_sec
    $error("SEC_CYCLES must be at least 2");
  end

  stg_port_state_t state_q;
  stg_port_state_t state_d;
  logic [7:0]  index_q;
  logic [7:0]  ldn_q;
  logic [7:0]  pinfn_q;
  logic [7:0]  act_q;
  logic [7:0]  unit_q;
  logic [7:0]  arld_q;
  logic [7:0]  count_q;
  logic [7:0]  reload_q;
  logic [31:0] presc_q;
  logic [5:0]  minsub_q;
  logic        timeout_q;
  logic        kbd_s1_q;
  logic        kbd_s2_q;
  logic        kbd_s3_q;
  logic        mouse_s1_q;
  logic        mouse_s2_q;
  logic        mouse_s3_q;

  logic        wr_idx;
  logic        wr_dat;
  logic        ldn_sel;
  logic        cnt_wr;
  logic        act_ok;
  logic        activity;
  logic        running;
  logic        sec_tick;
  logic        dec;
  logic        expire;
  logic        unit_min;

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
  localparam logic [5:0]  MIN_LAST = 6'(MIN_SECONDS - 1);

  function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic sel);
    logic [7:0] v;
    v = IDLE_RDATA;
    case (idx)
      REG_LDN:   v = ldn_q;
      REG_PINFN: v = pinfn_q;
      REG_ACT:   v = sel ? act_q : IDLE_RDATA;
      REG_UNIT:  v = sel ? unit_q : IDLE_RDATA;
      REG_COUNT: v = sel ? count_q : IDLE_RDATA;
      REG_ARLD:  v = sel ? arld_q : IDLE_RDATA;
      default:   v = IDLE_RDATA;
    endcase
    return v;
  endfunction

  // port decode
  assign wr_idx   = io_wr && (io_addr == INDEX_PORT);
  assign wr_dat   = io_wr && (io_addr == DATA_PORT) && (state_q == ST_OPEN);
  assign ldn_sel  = (ldn_q == LDN_GUARD);
  assign cnt_wr   = wr_dat && (index_q == REG_COUNT) && ldn_sel;
  assign unit_min = unit_q[UNIT_MIN_BIT];
  assign act_ok   = arld_q[ARLD_HI_BIT] && arld_q[ARLD_LO_BIT];
  // a disarmed guard ignores activity so a stray key cannot arm it
  assign activity = ((kbd_s2_q && !kbd_s3_q) || (mouse_s2_q && !mouse_s3_q)) && act_ok
                    && (reload_q != 8'h00) && !cnt_wr;
  assign running  = act_q[ACT_EN_BIT] && (count_q != 8'h00);
  assign sec_tick = running && (presc_q == SEC_LAST);
  assign dec      = sec_tick && (!unit_min || (minsub_q == MIN_LAST)) && !cnt_wr && !activity;
  assign expire   = dec && (count_q == 8'h01);

  // unlock key sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_LOCKED: begin
        if (wr_idx && io_wdata == UNLOCK_KEY) begin
          state_d = ST_HALF;
        end
      end
      ST_HALF: begin
        if (io_wr) begin
          state_d = (wr_idx && io_wdata == UNLOCK_KEY) ? ST_OPEN : ST_LOCKED;
        end
      end
      ST_OPEN: begin
        if (wr_idx && io_wdata == LOCK_KEY) begin
          state_d = ST_LOCKED;
        end
      end
      default: state_d = ST_LOCKED;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_LOCKED;
    end else begin
      state_q <= state_d;
    end
  end

  // index latch; the lock key itself is never taken as an index
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      index_q <= RST_INDEX;
    end else if (wr_idx && state_q == ST_OPEN && io_wdata != LOCK_KEY) begin
      index_q <= io_wdata;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ldn_q   <= RST_LDN;
      pinfn_q <= RST_PINFN;
      act_q   <= RST_ACT;
      unit_q  <= RST_UNIT;
      arld_q  <= RST_ARLD;
    end else if (wr_dat) begin
      case (index_q)
        REG_LDN:   ldn_q <= io_wdata;
        REG_PINFN: pinfn_q <= io_wdata;
        REG_ACT:   if (ldn_sel) act_q <= io_wdata;
        REG_UNIT:  if (ldn_sel) unit_q <= io_wdata;
        REG_ARLD:  if (ldn_sel) arld_q <= io_wdata;
        default:   ;
      endcase
    end
  end

  // read answer, one cycle after the strobe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata  <= IDLE_RDATA;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      if (io_rd) begin
        if (state_q != ST_OPEN) begin
          io_rdata <= IDLE_RDATA;
        end else if (io_addr == INDEX_PORT) begin
          io_rdata <= index_q;
        end else if (io_addr == DATA_PORT) begin
          io_rdata <= read_reg(index_q, ldn_sel);
        end else begin
          io_rdata <= IDLE_RDATA;
        end
      end
    end
  end

  // activity pins: two-stage sync, third stage for the edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      kbd_s1_q   <= 1'b0;
      kbd_s2_q   <= 1'b0;
      kbd_s3_q   <= 1'b0;
      mouse_s1_q <= 1'b0;
      mouse_s2_q <= 1'b0;
      mouse_s3_q <= 1'b0;
    end else begin
      kbd_s1_q   <= kbd_activity;
      kbd_s2_q   <= kbd_s1_q;
      kbd_s3_q   <= kbd_s2_q;
      mouse_s1_q <= mouse_activity;
      mouse_s2_q <= mouse_s1_q;
      mouse_s3_q <= mouse_s2_q;
    end
  end

  // one-second prescaler, restarted by every reload so a unit is never short
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_q <= 32'h0000_0000;
    end else if (cnt_wr || activity || !running || sec_tick) begin
      presc_q <= 32'h0000_0000;
    end else begin
      presc_q <= presc_q + 32'h0000_0001;
    end
  end

  // seconds within a minute
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      minsub_q <= 6'h00;
    end else if (cnt_wr || activity || !running || !unit_min) begin
      minsub_q <= 6'h00;
    end else if (sec_tick) begin
      minsub_q <= (minsub_q == MIN_LAST) ? 6'h00 : minsub_q + 6'h01;
    end
  end

  // down counter and its reload value
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q  <= RST_COUNT;
      reload_q <= RST_COUNT;
    end else if (cnt_wr) begin
      count_q  <= io_wdata;
      reload_q <= io_wdata;
    end else if (activity) begin
      count_q  <= reload_q;
    end else if (dec) begin
      count_q  <= count_q - 8'h01;
    end
  end

  // expiry flag; a count write blocks the final decrement, so the clear wins in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_q <= 1'b0;
    end else if (expire) begin
      timeout_q <= 1'b1;
    end else if (cnt_wr) begin
      timeout_q <= 1'b0;
    end
  end

  // outputs; the shared pin carries an active-low reset when routed to the guard
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_output <= 1'b0;
      pin_out        <= 1'b1;
      pin_oe         <= 1'b1;
    end else begin
      timeout_output <= timeout_q;
      pin_out        <= !timeout_q;
      pin_oe         <= !pinfn_q[PIN_GP_BIT];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_unlock_two_keys: assert property ((state_q == ST_OPEN) |-> ($past(state_q) != ST_LOCKED))
    else $error("port opened without two keys");
  a_relock_key: assert property ((state_q == ST_OPEN && wr_idx && io_wdata == LOCK_KEY)
    |=> (state_q == ST_LOCKED))
    else $error("lock key did not relock");
  a_count_load: assert property (cnt_wr |=> (count_q == $past(io_wdata)) && (reload_q == $past(io_wdata)))
    else $error("count write not loaded");
  a_activity_reload: assert property (activity |=> (count_q == $past(reload_q)))
    else $error("activity did not reload");
  a_activity_gated: assert property ((count_q > $past(count_q)) |-> $past(cnt_wr || activity))
    else $error("count rose without reload");
  a_ldn_gate: assert property ((wr_dat && index_q == REG_COUNT && !ldn_sel) |=> $stable(reload_q))
    else $error("count written with wrong device");
  a_expire_out: assert property (expire |-> ##2 timeout_output)
    else $error("expiry did not reach output");
  a_timeout_cause: assert property ($rose(timeout_q) |-> ($past(count_q) == 8'h01) && (count_q == 8'h00))
    else $error("timeout without expiry");
  a_unit_minute: assert property ((dec && unit_min) |-> (minsub_q == MIN_LAST))
    else $error("minute unit stepped early");
  a_second_step: assert property ((running && !unit_min && presc_q == SEC_LAST && !cnt_wr && !activity)
    |=> (count_q == $past(count_q) - 8'h01))
    else $error("second step missed");
  a_pin_route: assert property (!pinfn_q[PIN_GP_BIT] |=> pin_oe)
    else $error("pin not routed to guard");

  c_unlock: cover property (state_q == ST_HALF ##1 state_q == ST_OPEN);
  c_expire: cover property (expire);
  c_activity: cover property (activity);
  c_minute_dec: cover property (dec && unit_min);

endmodule
`default_nettype wire

// >>> test/stg_host.sv
// Purpose: host side of the index/data configuration port
// Assumes: strobes launched 1 ns after the rising mclk edge, one idle cycle between accesses
// Notes:   address and data are inverted when idle so a stale decode cannot pass
`timescale 1ns/1ps
`default_nettype none
module stg_host (
  input  wire logic        mclk,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rvalid,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [15:0] io_addr,
  output logic      [7:0]  io_wdata
);
  import stg_pkg::*;
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge mclk);
    #1;
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge mclk);
    #1;
    io_rd = 1'b0;
    io_addr = ~a;
    v = io_rvalid;
    d = io_rdata;
  endtask
  // key must be written twice with no other write in between
  task automatic unlock;
    wr(INDEX_PORT, UNLOCK_KEY);
    wr(INDEX_PORT, UNLOCK_KEY);
  endtask
  task automatic lock;
    wr(INDEX_PORT, LOCK_KEY);
  endtask
  task automatic set_reg(input logic [7:0] idx, input logic [7:0] val);
    wr(INDEX_PORT, {8'h00, idx});
    wr(DATA_PORT, val);
  endtask
  task automatic get_reg(input logic [7:0] idx, output logic [7:0] val, output logic v);
    wr(INDEX_PORT, {8'h00, idx});
    rd(DATA_PORT, val, v);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_config_port_watchdog_timer.sv
// Purpose: self-checking bench for the system timeout guard
// Assumes: SEC_CYCLES shortened to 8 so minute counts stay short
// Notes:   timeout checks leave a few cycles of margin around the expiry edge
`timescale 1ns/1ps
`default_nettype none
module tb_config_port_watchdog_timer;
  import stg_pkg::*;
  localparam int SEC = 8;
  logic        mclk;
  logic        sys_rst;
  logic        io_wr;
  logic        io_rd;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic        kbd_activity;
  logic        mouse_activity;
  logic        timeout_output;
  logic        pin_out;
  logic        pin_oe;
  logic [7:0]  rv;
  logic        vv;
  int          bad_count;
  int          num_checks;
  int          cyc;
  always #50 mclk = ~mclk;
  stg_top #(.SEC_CYCLES(SEC)) i_stg_top (.mclk(mclk), .sys_rst(sys_rst), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .kbd_activity(kbd_activity), .mouse_activity(mouse_activity), .timeout_output(timeout_output),
    .pin_out(pin_out), .pin_oe(pin_oe));
  stg_host i_stg_host (.mclk(mclk), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    i_stg_host.get_reg(idx, rv, vv);
    chk("rvalid", 8'h01, {7'h00, vv});
    chk("reg", e, rv);
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic to_chk(input int n, input logic e);
    cyc_wait(n);
    chk("timeout", {7'h00, e}, {7'h00, timeout_output});
    chk("pin_out", {7'h00, ~e}, {7'h00, pin_out});
  endtask
  // a short pulse, then idle long enough for the synchroniser to see the next rise
  task automatic act(input logic m);
    if (m) mouse_activity = 1'b1;
    else kbd_activity = 1'b1;
    cyc_wait(2);
    mouse_activity = 1'b0;
    kbd_activity = 1'b0;
    cyc_wait(8);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    kbd_activity = 1'b0;
    mouse_activity = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk("pin_oe", 8'h01, {7'h00, pin_oe});
    to_chk(0, 1'b0);
    i_stg_host.rd(DATA_PORT, rv, vv);
    chk("locked_rd", IDLE_RDATA, rv);
    i_stg_host.unlock();
    rchk(REG_LDN, RST_LDN);
    i_stg_host.rd(INDEX_PORT, rv, vv);
    chk("index_rd", REG_LDN, rv);
    i_stg_host.set_reg(REG_COUNT, 8'h05);
    rchk(REG_COUNT, IDLE_RDATA);
    i_stg_host.set_reg(REG_PINFN, 8'h10);
    cyc_wait(2);
    chk("pin_oe", 8'h00, {7'h00, pin_oe});
    i_stg_host.set_reg(REG_PINFN, 8'h00);
    cyc_wait(2);
    chk("pin_oe", 8'h01, {7'h00, pin_oe});
    i_stg_host.set_reg(REG_LDN, LDN_GUARD);
    i_stg_host.set_reg(REG_ACT, 8'h01);
    rchk(REG_COUNT, RST_COUNT);
    i_stg_host.set_reg(REG_UNIT, 8'h00);
    i_stg_host.set_reg(REG_COUNT, 8'h03);
    to_chk(20, 1'b0);
    to_chk(10, 1'b1);
    i_stg_host.set_reg(REG_COUNT, 8'hff);
    to_chk(4, 1'b0);
    to_chk(2026, 1'b0);
    to_chk(20, 1'b1);
    i_stg_host.set_reg(REG_ARLD, 8'h80);
    i_stg_host.set_reg(REG_COUNT, 8'h03);
    repeat (3) act(1'b0);
    to_chk(0, 1'b1);
    i_stg_host.set_reg(REG_ARLD, 8'hc0);
    i_stg_host.set_reg(REG_COUNT, 8'h03);
    repeat (3) act(1'b0);
    repeat (3) act(1'b1);
    to_chk(0, 1'b0);
    to_chk(30, 1'b1);
    i_stg_host.set_reg(REG_ARLD, 8'h00);
    i_stg_host.set_reg(REG_UNIT, 8'h08);
    i_stg_host.set_reg(REG_COUNT, 8'h01);
    to_chk(450, 1'b0);
    to_chk(50, 1'b1);
    i_stg_host.lock();
    i_stg_host.wr(DATA_PORT, 8'h00);
    i_stg_host.rd(DATA_PORT, rv, vv);
    chk("relocked_rd", IDLE_RDATA, rv);
    to_chk(5, 1'b1);
    // mid-run reset must drop the held timeout at once
    sys_rst = 1'b1;
    cyc_wait(2);
    sys_rst = 1'b0;
    to_chk(1, 1'b0);
    chk("pin_oe", 8'h01, {7'h00, pin_oe});
    tally_and_finish();
  end
endmodule
`default_nettype wire
